// [dv/host_io_model.sv]
module host_io_model
  import nmi_gate_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Host port access
  output io_req_type io_req,
  input wire logic [IO_DATA_W-1:0] io_rdata,
  input wire logic io_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial io_req = '0;
  // One-cycle strobe, released at the taking edge; read answer seen 1 ns after that edge
  task automatic access(input logic w, input logic [IO_ADDR_W-1:0] a,
    input logic [IO_DATA_W-1:0] d, output logic [IO_DATA_W-1:0] q);
    @(posedge sys_clk);
    io_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge sys_clk);
    io_req <= '0;
    #1;
    q = (w || io_rvalid === 1'b1) ? io_rdata : 'x;
  endtask
endmodule

// [dv/nmi_parity_error_gating_tb.sv]
module nmi_parity_error_gating_tb;
  import nmi_gate_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0;
  logic rst = 1;
  logic mem_parity_err = 0;
  logic iobus_parity_err = 0;
  io_req_type io_req;
  logic [IO_DATA_W-1:0] io_rdata, q;
  logic io_rvalid, rtc_index_wr, nmi_req;
  logic [RTC_IDX_W-1:0] rtc_index;
  int errors = 0;
  int n_checks = 0;
  initial forever #2 sys_clk = ~sys_clk;
  nmi_parity_error_gating dut (.sys_clk(sys_clk), .rst(rst), .io_req(io_req),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .mem_parity_err(mem_parity_err),
    .iobus_parity_err(iobus_parity_err), .rtc_index(rtc_index),
    .rtc_index_wr(rtc_index_wr), .nmi_req(nmi_req));
  host_io_model host (.sys_clk(sys_clk), .io_req(io_req), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    host.access(1'b0, a, 8'h00, q);
    chk("rdata", e, q);
  endtask
  task automatic pulse(input logic m, input logic i);
    @(posedge sys_clk);
    mem_parity_err <= m;
    iobus_parity_err <= i;
    @(posedge sys_clk);
    mem_parity_err <= 1'b0;
    iobus_parity_err <= 1'b0;
  endtask
  task automatic nmi_is(input logic e);
    @(posedge sys_clk);
    #1;
    chk("nmi", {7'h00, e}, {7'h00, nmi_req});
  endtask
  task automatic mem_case();
    pulse(1'b1, 1'b0);
    nmi_is(1'b1);
    rd(STATUS_PORT, 8'h80);
    wr(MASK_PORT, 8'h85);
    chk("rtc", 8'h85, {rtc_index_wr, rtc_index});
    nmi_is(1'b0);
    chk("rtc_wr", 8'h00, {7'h00, rtc_index_wr});
    rd(MASK_PORT, 8'h00);
    wr(MASK_PORT, 8'h00);
    nmi_is(1'b1);
    wr(CTRL_PORT, 8'h04);
    rd(STATUS_PORT, 8'h00);
    pulse(1'b1, 1'b0);
    rd(STATUS_PORT, 8'h00);
    chk("nmi", 8'h00, {7'h00, nmi_req});
    wr(CTRL_PORT, 8'h00);
    rd(STATUS_PORT, 8'h00);
  endtask
  task automatic io_case();
    wr(CTRL_PORT, 8'h08);
    pulse(1'b0, 1'b1);
    rd(STATUS_PORT, 8'h00);
    rd(CTRL_PORT, 8'h08);
    wr(CTRL_PORT, 8'h00);
    pulse(1'b0, 1'b1);
    rd(STATUS_PORT, 8'h40);
    nmi_is(1'b1);
    wr(CTRL_PORT, 8'h08);
    wr(CTRL_PORT, 8'h00);
    rd(STATUS_PORT, 8'h00);
  endtask
  task automatic reset_case();
    rd(CTRL_PORT, 8'h00);
    nmi_is(1'b0);
  endtask
  task automatic rerst_case();
    wr(MASK_PORT, 8'h80);
    wr(CTRL_PORT, 8'h0c);
    pulse(1'b1, 1'b1);
    rd(STATUS_PORT, 8'h00);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    reset_case();
    pulse(1'b1, 1'b1);
    nmi_is(1'b1);
    rd(STATUS_PORT, 8'hc0);
    wr(CTRL_PORT, 8'h0c);
    wr(CTRL_PORT, 8'h00);
    rd(STATUS_PORT, 8'h00);
  endtask
  task automatic report_and_stop();
    $display("errors %0d n_checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #20000;
    errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    reset_case();
    mem_case();
    io_case();
    rerst_case();
    report_and_stop();
  end
endmodule

// [logic/nmi_gate_pkg.sv]
// Overview of operation
// - NMI request rises only for memory parity or I/O bus parity errors.
// - Error sources are gated ahead of the NMI line so masking disconnects them.
// - Mask is write-only bit 7 of port 0070H; reads never return it.
// - Mask at 0 passes NMI sources; mask resets to 0.
// - Port 0070H writes also hand bits 6..0 to the clock index path.
// - Control port 0061H bit 2 at 0 enables memory parity checking; resets 0.
// - Control port 0061H bit 3 at 0 enables I/O bus checking; resets 0.
// - Status port 0062H bit 7 reads 1 after a memory parity error.
// - Memory error bit stays set until its check is disabled; disabling clears it.
// - Status port 0062H bit 6 reads 1 after an I/O bus parity error.
// - I/O error bit stays set until its check is disabled; disabling clears it.
package nmi_gate_pkg;

  localparam int IO_ADDR_W = 16;
  localparam int IO_DATA_W = 8;
  localparam int RTC_IDX_W = 7;

  localparam logic [IO_ADDR_W-1:0] CTRL_PORT = 16'h0061;
  localparam logic [IO_ADDR_W-1:0] STATUS_PORT = 16'h0062;
  localparam logic [IO_ADDR_W-1:0] MASK_PORT = 16'h0070;

  localparam int MASK_BIT = 7;
  localparam int MEM_DIS_BIT = 2;
  localparam int IO_DIS_BIT = 3;
  localparam int MEM_ERR_BIT = 7;
  localparam int IO_ERR_BIT = 6;

  localparam logic [IO_DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [IO_DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [RTC_IDX_W-1:0] RTC_IDX_RESET = 7'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [IO_ADDR_W-1:0] addr;
    logic [IO_DATA_W-1:0] wdata;
  } io_req_type;

  typedef struct packed {
    logic mask;
    logic [IO_DATA_W-1:0] ctrl;
    logic mem_err;
    logic io_err;
    logic nmi;
    logic [IO_DATA_W-1:0] rdata;
    logic rvalid;
    logic [RTC_IDX_W-1:0] rtc_idx;
    logic rtc_wr;
  } state_type;

endpackage

// [logic/nmi_parity_error_gating.sv]
module nmi_parity_error_gating
  import nmi_gate_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host I/O port access
  input wire io_req_type io_req,
  output logic [IO_DATA_W-1:0] io_rdata,
  output logic io_rvalid,
  // Error sources
  input wire logic mem_parity_err,
  input wire logic iobus_parity_err,
  // Clock index path shared with the mask port
  output logic [RTC_IDX_W-1:0] rtc_index,
  output logic rtc_index_wr,
  // Processor non-maskable request
  output logic nmi_req
);

  state_type s_q;
  state_type s_d;

  logic wr_ctrl;
  logic wr_mask;
  logic rd_ctrl;
  logic rd_status;

  assign wr_ctrl = io_req.wr && (io_req.addr == CTRL_PORT);
  assign wr_mask = io_req.wr && (io_req.addr == MASK_PORT);
  assign rd_ctrl = io_req.rd && (io_req.addr == CTRL_PORT);
  assign rd_status = io_req.rd && (io_req.addr == STATUS_PORT);

  always_comb
  begin
    s_d = s_q;
    s_d.rtc_wr = 1'b0;
    s_d.rvalid = io_req.rd;
    if (wr_mask)
    begin
      s_d.mask = io_req.wdata[MASK_BIT];
      s_d.rtc_idx = io_req.wdata[RTC_IDX_W-1:0];
      s_d.rtc_wr = 1'b1;
    end
    if (wr_ctrl)
    begin
      s_d.ctrl = io_req.wdata;
    end
    // Sticky latches; a new error while enabled always wins over holding
    s_d.mem_err = !s_q.ctrl[MEM_DIS_BIT] && (s_q.mem_err || mem_parity_err);
    s_d.io_err = !s_q.ctrl[IO_DIS_BIT] && (s_q.io_err || iobus_parity_err);
    // Only the two latches reach the gate, and the mask sits before the line
    s_d.nmi = (s_q.mem_err || s_q.io_err) && !s_q.mask;
    // Mask port and unmapped ports read as zero
    s_d.rdata = READ_ZERO;
    if (rd_ctrl)
    begin
      s_d.rdata = s_q.ctrl;
    end
    else if (rd_status)
    begin
      s_d.rdata[MEM_ERR_BIT] = s_q.mem_err;
      s_d.rdata[IO_ERR_BIT] = s_q.io_err;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q.mask <= 1'b0;
      s_q.ctrl <= CTRL_RESET;
      s_q.mem_err <= 1'b0;
      s_q.io_err <= 1'b0;
      s_q.nmi <= 1'b0;
      s_q.rdata <= READ_ZERO;
      s_q.rvalid <= 1'b0;
      s_q.rtc_idx <= RTC_IDX_RESET;
      s_q.rtc_wr <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign io_rdata = s_q.rdata;
  assign io_rvalid = s_q.rvalid;
  assign rtc_index = s_q.rtc_idx;
  assign rtc_index_wr = s_q.rtc_wr;
  assign nmi_req = s_q.nmi;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Write to the mask port, as presented on the request in one cycle
  sequence s_mask_write;
    io_req.wr && (io_req.addr == MASK_PORT);
  endsequence

  sequence s_status_read;
    io_req.rd && (io_req.addr == STATUS_PORT);
  endsequence

  sequence s_ctrl_write;
    io_req.wr && (io_req.addr == CTRL_PORT);
  endsequence

  // First half of the clear toggle: a control write that turns a check off
  sequence s_mem_check_off;
    wr_ctrl && io_req.wdata[MEM_DIS_BIT];
  endsequence

  sequence s_io_check_off;
    wr_ctrl && io_req.wdata[IO_DIS_BIT];
  endsequence

  property p_nmi_raised;
    (s_q.mem_err || s_q.io_err) && !s_q.mask |=> nmi_req;
  endproperty
  a_nmi_raised: assert property (p_nmi_raised) else $error("NMI not raised for latched error");

  property p_nmi_no_source;
    !s_q.mem_err && !s_q.io_err |=> !nmi_req;
  endproperty
  a_nmi_no_source: assert property (p_nmi_no_source) else $error("NMI raised without source");

  property p_nmi_masked;
    s_q.mask |=> !nmi_req;
  endproperty
  a_nmi_masked: assert property (p_nmi_masked) else $error("NMI passed while masked");

  property p_mask_take;
    s_mask_write |=> (s_q.mask == $past(io_req.wdata[MASK_BIT]));
  endproperty
  a_mask_take: assert property (p_mask_take) else $error("Mask bit not taken from write");

  property p_mask_hidden;
    io_req.rd && (io_req.addr == MASK_PORT) |=> io_rvalid && (io_rdata == READ_ZERO);
  endproperty
  a_mask_hidden: assert property (p_mask_hidden) else $error("Mask port read not zero");

  property p_reset_defaults;
    $past(rst) |-> !s_q.mask && (s_q.ctrl == CTRL_RESET) && !nmi_req;
  endproperty
  a_reset_defaults: assert property (@(posedge sys_clk) p_reset_defaults)
    else $error("Wrong state after reset");

  property p_rtc_path;
    s_mask_write |=> rtc_index_wr && (rtc_index == $past(io_req.wdata[RTC_IDX_W-1:0]));
  endproperty
  a_rtc_path: assert property (p_rtc_path) else $error("Clock index not forwarded");

  property p_mem_set;
    mem_parity_err && !s_q.ctrl[MEM_DIS_BIT] |=> s_q.mem_err;
  endproperty
  a_mem_set: assert property (p_mem_set) else $error("Memory error not latched");

  property p_io_set;
    iobus_parity_err && !s_q.ctrl[IO_DIS_BIT] |=> s_q.io_err ##1 (nmi_req || $past(s_q.mask));
  endproperty
  a_io_set: assert property (p_io_set) else $error("I/O error not latched or signalled");

  property p_status_read;
    s_status_read |=> io_rvalid && (io_rdata[MEM_ERR_BIT] == $past(s_q.mem_err))
      && (io_rdata[IO_ERR_BIT] == $past(s_q.io_err));
  endproperty
  a_status_read: assert property (p_status_read) else $error("Status bits read wrong");

  property p_mem_sticky;
    s_q.mem_err && !s_q.ctrl[MEM_DIS_BIT] |=> s_q.mem_err;
  endproperty
  a_mem_sticky: assert property (p_mem_sticky) else $error("Memory error lost");

  property p_io_sticky;
    s_q.io_err && !s_q.ctrl[IO_DIS_BIT] |=> s_q.io_err;
  endproperty
  a_io_sticky: assert property (p_io_sticky) else $error("I/O error lost");

  property p_held_clear;
    s_q.ctrl[MEM_DIS_BIT] && s_q.ctrl[IO_DIS_BIT] |=> !s_q.mem_err && !s_q.io_err ##1 !nmi_req;
  endproperty
  a_held_clear: assert property (p_held_clear) else $error("Latch set while check disabled");

  property p_ctrl_take;
    s_ctrl_write |=> (s_q.ctrl == $past(io_req.wdata));
  endproperty
  a_ctrl_take: assert property (p_ctrl_take) else $error("Control byte not stored");

  property p_ctrl_hold;
    !wr_ctrl |=> $stable(s_q.ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("Control byte moved without write");

  property p_mask_hold;
    !wr_mask |=> $stable(s_q.mask);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("Mask moved without write");

  property p_rtc_quiet;
    !wr_mask |=> !rtc_index_wr;
  endproperty
  a_rtc_quiet: assert property (p_rtc_quiet) else $error("Clock index strobe without write");

  property p_mem_held_clear;
    s_q.ctrl[MEM_DIS_BIT] |=> !s_q.mem_err;
  endproperty
  a_mem_held_clear: assert property (p_mem_held_clear) else $error("Memory latch set while off");

  property p_io_held_clear;
    s_q.ctrl[IO_DIS_BIT] |=> !s_q.io_err;
  endproperty
  a_io_held_clear: assert property (p_io_held_clear) else $error("I/O latch set while off");

  property p_mem_no_source;
    !s_q.mem_err && !mem_parity_err |=> !s_q.mem_err;
  endproperty
  a_mem_no_source: assert property (p_mem_no_source) else $error("Memory latch set alone");

  property p_io_no_source;
    !s_q.io_err && !iobus_parity_err |=> !s_q.io_err;
  endproperty
  a_io_no_source: assert property (p_io_no_source) else $error("I/O latch set alone");

  property p_mem_clear;
    s_mem_check_off |=> ##1 !s_q.mem_err;
  endproperty
  a_mem_clear: assert property (p_mem_clear) else $error("Memory latch kept after check off");

  property p_io_clear;
    s_io_check_off |=> ##1 !s_q.io_err;
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("I/O latch kept after check off");

  property p_status_spare;
    s_status_read |=> (io_rdata[IO_ERR_BIT-1:0] == '0);
  endproperty
  a_status_spare: assert property (p_status_spare) else $error("Spare status bits set");

endmodule
